// [rtl/gsmc_ctrl.v]
/*
  Setting group selection and maintenance mode control with a small register port.
  Assumes inputs synchronous to i_mclk; power-up is the asynchronous reset.
*/
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ns
`include "gsmc_consts.vh"
module gsmc_ctrl #(
  parameter N_OUT = 8,
  parameter N_LED = 8,
  parameter MAINT_MS = `GSMC_MAINT_MS,
  parameter MS_DIV = `GSMC_MS_DIV
) (
  // Clock and reset
  input wire i_mclk,
  input wire i_nrst,
  // Register port
  input wire [3:0] i_addr,
  input wire [15:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [15:0] o_rdata,
  // Binary inputs
  input wire i_group_select_input,
  input wire i_maint_input_cfg,
  input wire i_maint_input,
  // Remote commands
  input wire i_remote_bank_cmd,
  input wire i_remote_bank_val,
  input wire i_remote_maint_cmd,
  input wire [1:0] i_remote_maint_val,
  // Protection function requests
  input wire [N_OUT-1:0] i_out_func,
  input wire [N_LED-1:0] i_led_func,
  input wire i_trip_func,
  input wire i_report_req,
  // Outputs
  output reg [N_OUT-1:0] o_contact,
  output reg [N_LED-1:0] o_led,
  output reg o_trip_led,
  output reg o_alarm_led,
  output reg o_bank_two,
  output reg o_maint_active,
  output reg o_tests_visible,
  output reg o_report_send,
  output reg o_report_maint_tag,
  output reg o_irq
);
  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_TWO = 3'b100;

  // Register port decode, shared by the register writes and the IRQ read clear
  function reg_hit;
    input strobe;
    input [3:0] addr;
    input [3:0] offset;
    begin
      reg_hit = strobe && (addr == offset);
    end
  endfunction

  wire ms_tick;
  reg [7:0] ctrl;
  reg [15:0] gdly_ms;
  reg [`GSMC_EV_W-1:0] irq_stat;
  reg [`GSMC_EV_W-1:0] irq_mask;
  reg [2:0] gstate;
  reg [15:0] gcount;
  reg [23:0] mcount;
  reg powered;
  reg [1:0] maint_src;
  reg [1:0] next_maint_src;
  reg panel_src;
  reg maint_prev;
  reg bank_prev;
  reg [`GSMC_EV_W-1:0] events;
  reg timeout;
  reg drop;

  wire two_groups = ctrl[`GSMC_CTRL_TWO_GROUPS];
  wire input_cfg = ctrl[`GSMC_CTRL_INPUT_CFG];
  // Remote bank command lands in the shared panel cell only while no input owns the selection
  wire remote_bank_ok = i_remote_bank_cmd && !input_cfg;
  wire input_lvl = i_group_select_input ^ ctrl[`GSMC_CTRL_INPUT_INV];
  wire modbus = (ctrl[`GSMC_CTRL_PROTO] == `GSMC_PROTO_MODBUS);
  wire [1:0] panel_maint = ctrl[`GSMC_CTRL_MAINT_HI:`GSMC_CTRL_MAINT_LO];
  wire rear_maint_ok = i_remote_maint_cmd && modbus;
  wire bank_sel_fsm = (gstate == ST_TWO);
  wire bank_now = two_groups && (input_cfg ? bank_sel_fsm : ctrl[`GSMC_CTRL_PANEL_BANK]);
  wire maint_on = (maint_src != `GSMC_MAINT_NO);
  wire reg_wr_ctrl = reg_hit(i_wr, i_addr, `GSMC_REG_CTRL);
  wire blocked = (maint_src == `GSMC_MAINT_BLOCK);

  gsmc_ms_tick #(
    .DIV(MS_DIV)
  ) u_tick (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .o_tick(ms_tick)
  );

  // Group input state machine; the delay is waived on the first cycle after power-up
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      gstate <= ST_IDLE;
      gcount <= 16'h0000;
      powered <= 1'b0;
    end else begin
      powered <= 1'b1;
      case (gstate)
        ST_IDLE: begin
          gcount <= 16'h0000;
          if (input_lvl && !powered) begin
            gstate <= ST_TWO;
          end else if (input_lvl) begin
            gstate <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (!input_lvl) begin
            gstate <= ST_IDLE;
          end else if (gcount >= gdly_ms) begin
            gstate <= ST_TWO;
          end else if (ms_tick) begin
            gcount <= gcount + 16'h0001;
          end
        end
        ST_TWO: begin
          if (!input_lvl) begin
            gstate <= ST_IDLE;
          end
        end
        default: gstate <= ST_IDLE;
      endcase
    end
  end

  // Maintenance source resolution: panel setting first, then the input, then the rear command; value 3 means off
  always @* begin
    next_maint_src = `GSMC_MAINT_NO;
    if (panel_maint != `GSMC_MAINT_NO) begin
      next_maint_src = panel_maint;
    end else if (i_maint_input_cfg && i_maint_input) begin
      next_maint_src = `GSMC_MAINT_BLOCK;
    end else if (rear_maint_ok) begin
      next_maint_src = i_remote_maint_val;
    end
    if (next_maint_src == 2'h3) begin
      next_maint_src = `GSMC_MAINT_NO;
    end
  end

  // Registers, maintenance timeout and event detection
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl <= `GSMC_CTRL_RST;
      gdly_ms <= `GSMC_GDLY_MS_DEF;
      irq_mask <= {`GSMC_EV_W{1'b0}};
      irq_stat <= {`GSMC_EV_W{1'b0}};
      mcount <= 24'h000000;
      panel_src <= 1'b0;
      maint_src <= `GSMC_MAINT_NO;
      maint_prev <= 1'b0;
      bank_prev <= 1'b0;
      o_rdata <= 16'h0000;
    end else begin
      maint_src <= next_maint_src;
      maint_prev <= maint_on;
      bank_prev <= bank_now;
      if (reg_wr_ctrl) begin
        ctrl <= i_wdata[7:0];
      end else if (remote_bank_ok) begin
        ctrl[`GSMC_CTRL_PANEL_BANK] <= i_remote_bank_val;
      end
      // Timeout comes last so it wins over a setting write in the same cycle
      if (timeout) begin
        ctrl[`GSMC_CTRL_MAINT_HI:`GSMC_CTRL_MAINT_LO] <= `GSMC_MAINT_NO;
      end
      if (reg_hit(i_wr, i_addr, `GSMC_REG_GDLY)) begin
        gdly_ms <= i_wdata;
      end
      if (reg_hit(i_wr, i_addr, `GSMC_REG_MASK)) begin
        irq_mask <= i_wdata[`GSMC_EV_W-1:0];
      end
      // Panel timer restarts each time the setting leaves the disabled value
      panel_src <= (panel_maint != `GSMC_MAINT_NO);
      if ((panel_maint == `GSMC_MAINT_NO) || !panel_src) begin
        mcount <= 24'h000000;
      end else if (ms_tick) begin
        mcount <= mcount + 24'h000001;
      end
      // Set wins over the read clear
      if (reg_hit(i_rd, i_addr, `GSMC_REG_IRQ)) begin
        irq_stat <= events;
      end else begin
        irq_stat <= irq_stat | events;
      end
      o_rdata <= 16'h0000;
      if (i_rd) begin
        case (i_addr)
          `GSMC_REG_CTRL: o_rdata <= {8'h00, ctrl};
          `GSMC_REG_GDLY: o_rdata <= gdly_ms;
          `GSMC_REG_STAT: o_rdata <= {9'h000, gstate, maint_src, o_maint_active, o_bank_two};
          `GSMC_REG_IRQ: o_rdata <= {{(16-`GSMC_EV_W){1'b0}}, irq_stat};
          `GSMC_REG_MASK: o_rdata <= {{(16-`GSMC_EV_W){1'b0}}, irq_mask};
          default: o_rdata <= 16'h0000;
        endcase
      end
    end
  end

  always @* begin
    timeout = panel_src && (panel_maint != `GSMC_MAINT_NO) && (mcount >= MAINT_MS[23:0]);
    // Remote bank command while input owns the selection is discarded, never stored
    drop = i_remote_bank_cmd && input_cfg;
    events = {`GSMC_EV_W{1'b0}};
    events[`GSMC_EV_BANK] = bank_now != bank_prev;
    events[`GSMC_EV_MAINT_ON] = maint_on && !maint_prev;
    events[`GSMC_EV_MAINT_OFF] = !maint_on && maint_prev;
    events[`GSMC_EV_TIMEOUT] = timeout;
    events[`GSMC_EV_REMOTE_DROP] = drop;
  end

  // Outputs: all registered
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_contact <= {N_OUT{1'b0}};
      o_led <= {N_LED{1'b0}};
      o_trip_led <= 1'b0;
      o_alarm_led <= 1'b0;
      o_bank_two <= 1'b0;
      o_maint_active <= 1'b0;
      o_tests_visible <= 1'b0;
      o_report_send <= 1'b0;
      o_report_maint_tag <= 1'b0;
      o_irq <= 1'b0;
    end else begin
      o_bank_two <= bank_now;
      o_contact <= blocked ? {N_OUT{1'b0}} : i_out_func;
      o_led <= i_led_func;
      o_trip_led <= i_trip_func;
      o_alarm_led <= maint_on;
      o_maint_active <= maint_on;
      o_tests_visible <= maint_on;
      o_report_send <= i_report_req && !(maint_on && modbus);
      o_report_maint_tag <= i_report_req && maint_on && !modbus;
      o_irq <= |(irq_stat & irq_mask);
    end
  end
endmodule // gsmc_ctrl

// [rtl/gsmc_consts.vh]
/*
  Constants for the group select and maintenance control block.
  Assumes a 25 MHz system clock; included by bare name.
*/
`ifndef GSMC_CONSTS_VH
`define GSMC_CONSTS_VH

// System clock rate in Hz
`define GSMC_CLK_HZ 25000000
// Millisecond tick divider count
`define GSMC_MS_DIV (`GSMC_CLK_HZ / 1000)
// Maintenance timeout in minutes and in milliseconds
`define GSMC_MAINT_MIN 5
`define GSMC_MAINT_MS (`GSMC_MAINT_MIN * 60 * 1000)
// Default group change delay in milliseconds
`define GSMC_GDLY_MS_DEF 16'h0064

// Maintenance setting encodings
`define GSMC_MAINT_NO 2'h0
`define GSMC_MAINT_TRIPS 2'h1
`define GSMC_MAINT_BLOCK 2'h2

// Rear protocol encodings
`define GSMC_PROTO_MODBUS 1'h0
`define GSMC_PROTO_IEC103 1'h1

// Register offsets (word addresses)
`define GSMC_REG_CTRL 4'h0
`define GSMC_REG_GDLY 4'h1
`define GSMC_REG_STAT 4'h2
`define GSMC_REG_IRQ 4'h3
`define GSMC_REG_MASK 4'h4

// Control register fields
`define GSMC_CTRL_TWO_GROUPS 0
`define GSMC_CTRL_PANEL_BANK 1
`define GSMC_CTRL_INPUT_CFG 2
`define GSMC_CTRL_INPUT_INV 3
`define GSMC_CTRL_MAINT_LO 4
`define GSMC_CTRL_MAINT_HI 5
`define GSMC_CTRL_PROTO 6
`define GSMC_CTRL_RST 8'h01

// Event bits
`define GSMC_EV_BANK 0
`define GSMC_EV_MAINT_ON 1
`define GSMC_EV_MAINT_OFF 2
`define GSMC_EV_TIMEOUT 3
`define GSMC_EV_REMOTE_DROP 4
`define GSMC_EV_W 5

`endif

// [rtl/gsmc_ms_tick.v]
/*
  Millisecond tick divider: one-cycle enable every DIV clocks.
  Assumes a single free-running system clock.
*/
`timescale 1ns/1ns
`include "gsmc_consts.vh"
module gsmc_ms_tick #(
  parameter DIV = `GSMC_MS_DIV
) (
  // Clock and reset
  input wire i_mclk,
  input wire i_nrst,
  // Tick output
  output reg o_tick
);
  reg [15:0] count;

  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      count <= 16'h0000;
      o_tick <= 1'b0;
    end else if (count == DIV[15:0] - 16'h0001) begin
      count <= 16'h0000;
      o_tick <= 1'b1;
    end else begin
      count <= count + 16'h0001;
      o_tick <= 1'b0;
    end
  end
endmodule // gsmc_ms_tick

// [test/gsmc_ctrl_chk.sv]
/* Port checker for gsmc_ctrl.
   Bound from the testbench top. */
`timescale 1ns/1ns
module gsmc_ctrl_chk #(
  parameter N_OUT = 8,
  parameter N_LED = 8
) (
  // Clock and reset
  input wire i_mclk,
  input wire i_nrst,
  // Watched ports
  input wire [N_OUT-1:0] i_out_func,
  input wire [N_LED-1:0] i_led_func,
  input wire i_trip_func,
  input wire [N_OUT-1:0] o_contact,
  input wire [N_LED-1:0] o_led,
  input wire o_trip_led,
  input wire o_alarm_led,
  input wire o_bank_two,
  input wire o_maint_active,
  input wire o_tests_visible,
  input wire o_report_send,
  input wire o_report_maint_tag
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  property p_led; $past(i_nrst) |-> o_led == $past(i_led_func); endproperty
  a_led: assert property (p_led) else $error("led bad");
  property p_trip; $past(i_nrst) |-> o_trip_led == $past(i_trip_func); endproperty
  a_trip: assert property (p_trip) else $error("trip led bad");
  property p_alarm; o_alarm_led == o_maint_active; endproperty
  a_alarm: assert property (p_alarm) else $error("alarm bad");
  property p_tests; o_tests_visible == o_maint_active; endproperty
  a_tests: assert property (p_tests) else $error("tests bad");
  property p_contact; o_contact != 0 |-> o_contact == $past(i_out_func); endproperty
  a_contact: assert property (p_contact) else $error("contact bad");
  property p_block; $past(i_nrst) && o_contact != $past(i_out_func) |-> o_maint_active; endproperty
  a_block: assert property (p_block) else $error("block bad");
  property p_tag; o_report_maint_tag |-> o_report_send && o_maint_active; endproperty
  a_tag: assert property (p_tag) else $error("tag bad");
  property p_pwrup; !$past(i_nrst) |-> !o_maint_active && !o_bank_two && o_contact == 0; endproperty
  a_pwrup: assert property (p_pwrup) else $error("power-up bad");
endmodule // gsmc_ctrl_chk

// [test/gsmc_partner.sv]
/* Stand-in for the protection elements feeding gsmc_ctrl.
   Assumes the bench clock and reset. */
`timescale 1ns/1ns
module gsmc_partner (
  // Clock and reset
  input wire i_mclk,
  input wire i_nrst,
  // Active bank, mapped onto an indicator by the configurer
  input wire i_bank_two,
  // Function requests
  output reg [7:0] o_out_func,
  output reg [7:0] o_led_func,
  output reg o_trip_func,
  output reg o_report_req
);
  integer seed = 80344;
  // Bit 0 always requested so blocking shows on every check
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_out_func <= 8'h00;
      o_led_func <= 8'h00;
      o_trip_func <= 1'h0;
      o_report_req <= 1'h0;
    end else begin
      o_out_func <= 8'($random(seed)) | 8'h01;
      o_led_func <= (8'($random(seed)) & 8'hFC) | {6'h00, i_bank_two, 1'h1};
      o_trip_func <= 1'($random(seed));
      o_report_req <= 1'h1;
    end
  end
endmodule // gsmc_partner

// [test/tb_gsmc_ctrl.sv]
/* Testbench for gsmc_ctrl.
   Assumes tick divider 4 and a 5 ms maintenance span. */
`timescale 1ns/1ns
module tb_gsmc_ctrl;
  reg i_mclk, i_nrst, i_wr, i_rd, i_group_select_input, i_maint_input_cfg, i_maint_input;
  reg i_remote_bank_cmd, i_remote_bank_val, i_remote_maint_cmd, rd_d;
  reg [1:0] i_remote_maint_val;
  reg [3:0] i_addr;
  reg [15:0] i_wdata;
  wire [15:0] o_rdata;
  wire [7:0] i_out_func, i_led_func, o_contact, o_led;
  wire i_trip_func, i_report_req, o_trip_led, o_alarm_led, o_bank_two, o_maint_active;
  wire o_tests_visible, o_report_send, o_report_maint_tag, o_irq;
  reg [31:0] q[$];
  integer fails, checks_done;
  gsmc_ctrl #(.MAINT_MS(5), .MS_DIV(4)) i_gsmc_ctrl (.i_mclk, .i_nrst, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_group_select_input, .i_maint_input_cfg, .i_maint_input, .i_remote_bank_cmd,
    .i_remote_bank_val, .i_remote_maint_cmd, .i_remote_maint_val, .i_out_func, .i_led_func,
    .i_trip_func, .i_report_req, .o_contact, .o_led, .o_trip_led, .o_alarm_led, .o_bank_two,
    .o_maint_active, .o_tests_visible, .o_report_send, .o_report_maint_tag, .o_irq);
  gsmc_partner i_gsmc_partner (.i_mclk, .i_nrst, .i_bank_two(o_bank_two), .o_out_func(i_out_func),
    .o_led_func(i_led_func),
    .o_trip_func(i_trip_func), .o_report_req(i_report_req));
  task chk(input [15:0] g, input [15:0] e);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("Error at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task conclude;
    begin
      $display("Checks %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task tk(input integer n);
    begin
      repeat (n) @(posedge i_mclk);
      #1;
    end
  endtask
  task wr(input [3:0] a, input [15:0] d);
    begin
      @(posedge i_mclk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'h1;
      @(posedge i_mclk);
      i_wr <= 1'h0;
    end
  endtask
  // Each read notes its expectation and a mask of the bits that are known
  task rd(input [3:0] a, input [15:0] e, input [15:0] m);
    begin
      @(posedge i_mclk);
      i_addr <= a;
      i_rd <= 1'h1;
      q.push_back({m, e});
      @(posedge i_mclk);
      i_rd <= 1'h0;
    end
  endtask
  always @(posedge i_mclk) begin
    if (rd_d) begin
      chk(o_rdata & q[0][31:16], q[0][15:0]);
      void'(q.pop_front());
    end
    rd_d <= i_rd;
  end
  initial begin
    i_mclk = 1'h0;
    forever #20 i_mclk = ~i_mclk;
  end
  initial begin
    repeat (3000) @(posedge i_mclk);
    fails = fails + 1;
    conclude;
  end
  initial begin
    {fails, checks_done} = 0;
    {i_nrst, i_wr, i_rd, i_group_select_input, i_maint_input_cfg, i_maint_input} = 0;
    {i_remote_bank_cmd, i_remote_bank_val, i_remote_maint_cmd, i_remote_maint_val, i_addr, i_wdata} = 0;
    repeat (12) @(posedge i_mclk);
    i_nrst <= 1'h1;
    rd(4'h0, 16'h0001, 16'hFFFF);
    rd(4'h1, 16'h0064, 16'hFFFF);
    rd(4'hF, 16'h0000, 16'hFFFF);
    wr(4'h1, 16'h0002);
    wr(4'h4, 16'h0011);
    $display("Register test done");
    wr(4'h0, 16'h0005);
    @(posedge i_mclk) i_group_select_input <= 1'h1;
    tk(2);
    chk(o_bank_two, 1'h0);
    tk(40);
    chk(o_bank_two, 1'h1);
    chk(o_led[1], 1'h1);
    chk(o_irq, 1'h1);
    rd(4'h3, 16'h0001, 16'h0001);
    tk(3);
    chk(o_irq, 1'h0);
    wr(4'h0, 16'h0007);
    @(posedge i_mclk) i_group_select_input <= 1'h0;
    tk(3);
    chk(o_bank_two, 1'h0);
    wr(4'h0, 16'h0005);
    @(posedge i_mclk) {i_remote_bank_cmd, i_remote_bank_val} <= 2'h3;
    @(posedge i_mclk) i_remote_bank_cmd <= 1'h0;
    tk(3);
    chk(o_irq, 1'h1);
    rd(4'h3, 16'h0010, 16'h0010);
    rd(4'h0, 16'h0005, 16'hFFFF);
    wr(4'h0, 16'h0001);
    tk(3);
    chk(o_bank_two, 1'h0);
    @(posedge i_mclk) {i_remote_bank_cmd, i_remote_bank_val} <= 2'h3;
    @(posedge i_mclk) i_remote_bank_cmd <= 1'h0;
    tk(3);
    chk(o_bank_two, 1'h1);
    rd(4'h0, 16'h0003, 16'hFFFF);
    wr(4'h0, 16'h0003);
    tk(3);
    chk(o_bank_two, 1'h1);
    wr(4'h0, 16'h0002);
    tk(3);
    chk(o_bank_two, 1'h0);
    $display("Group test done");
    wr(4'h0, 16'h0021);
    tk(3);
    chk({o_maint_active, o_alarm_led, o_contact[0], o_led[0]}, 4'hD);
    chk(o_report_send, 1'h0);
    tk(30);
    chk(o_maint_active, 1'h0);
    rd(4'h0, 16'h0000, 16'h0030);
    wr(4'h0, 16'h0061);
    tk(3);
    chk({o_report_send, o_report_maint_tag}, 2'h3);
    wr(4'h0, 16'h0011);
    tk(3);
    chk({o_contact[0], o_tests_visible}, 2'h3);
    wr(4'h0, 16'h0001);
    tk(3);
    chk({o_maint_active, o_tests_visible}, 2'h0);
    @(posedge i_mclk) {i_maint_input_cfg, i_maint_input} <= 2'h3;
    tk(4);
    chk({o_maint_active, o_contact[0]}, 2'h2);
    @(posedge i_mclk) i_maint_input <= 1'h0;
    tk(4);
    chk(o_maint_active, 1'h0);
    @(posedge i_mclk) {i_remote_maint_cmd, i_remote_maint_val} <= 3'h5;
    tk(4);
    chk(o_maint_active, 1'h1);
    wr(4'h0, 16'h0041);
    tk(4);
    chk(o_maint_active, 1'h0);
    $display("Maintenance test done");
    // Power loss in mid-run: mode must be off, and a high bank input skips the delay
    @(posedge i_mclk) begin
      i_nrst <= 1'h0;
      i_remote_maint_cmd <= 1'h0;
      i_group_select_input <= 1'h1;
    end
    repeat (3) @(posedge i_mclk);
    i_nrst <= 1'h1;
    tk(1);
    chk({o_maint_active, o_bank_two}, 2'h0);
    rd(4'h0, 16'h0001, 16'hFFFF);
    wr(4'h0, 16'h0005);
    tk(3);
    chk(o_bank_two, 1'h1);
    $display("Reset test done");
    conclude;
  end
endmodule // tb_gsmc_ctrl
bind gsmc_ctrl gsmc_ctrl_chk #(.N_OUT(N_OUT), .N_LED(N_LED)) i_gsmc_ctrl_chk (.i_mclk, .i_nrst, .i_out_func,
  .i_led_func, .i_trip_func, .o_contact, .o_led, .o_trip_led, .o_alarm_led, .o_bank_two, .o_maint_active,
  .o_tests_visible, .o_report_send, .o_report_maint_tag);
